// ==== include/shrp_pkg.sv ====
// constants and types of the serial host register port
`default_nettype none
package shrp_pkg;
   // two-wire slave addresses selected by the strap
   localparam logic [6:0] SHRP_DEV_ADDR_LOW = 7'h16;
   localparam logic [6:0] SHRP_DEV_ADDR_HIGH = 7'h17;
   // four-wire command bytes ahead of the address byte
   localparam logic [7:0] SHRP_SPI_CMD_WRITE = 8'h02;
   localparam logic [7:0] SHRP_SPI_CMD_READ = 8'h03;
   // bit counter: 0..7 data bits, 8 is the acknowledge slot
   localparam logic [3:0] SHRP_BIT_LAST = 4'h7;
   localparam logic [3:0] SHRP_BIT_ACK = 4'h8;
   localparam logic [3:0] SHRP_BIT_RST = 4'h0;
   localparam logic [7:0] SHRP_PTR_RST = 8'h00;
   // synchroniser lanes
   localparam int SHRP_SYNC_W = 7;
   localparam int SHRP_SY_SCL = 0;
   localparam int SHRP_SY_SDA = 1;
   localparam int SHRP_SY_SCK = 2;
   localparam int SHRP_SY_SI = 3;
   localparam int SHRP_SY_CSN = 4;
   localparam int SHRP_SY_STRAP = 5;
   localparam int SHRP_SY_SPI = 6;
   localparam logic [SHRP_SYNC_W-1:0] SHRP_SYNC_RST = 7'h13;

   typedef enum logic [3:0] {
      SHRP_IDLE = 4'h0,
      SHRP_I_DEV = 4'h1,
      SHRP_I_PTR = 4'h2,
      SHRP_I_WR = 4'h3,
      SHRP_I_RD = 4'h4,
      SHRP_S_CMD = 4'h5,
      SHRP_S_ADDR = 4'h6,
      SHRP_S_WR = 4'h7,
      SHRP_S_RD = 4'h8,
      SHRP_S_SKIP = 4'h9
   } shrp_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } shrp_req_t;

   localparam shrp_req_t SHRP_REQ_RST = '0;
endpackage
`default_nettype wire

// ==== rtl/shrp_port.sv ====
// two-wire / four-wire serial slave giving a host burst access to registers
`default_nettype none
// Functional notes
// (R1) two-wire write: each data byte stored at pointer, pointer then increments
// (R2) two-wire read: each byte sent comes from pointer, pointer then increments
// (R3) strap low: answer slave address 0x16 (bytes 0x2C write, 0x2D read)
// (R4) strap high: answer slave address 0x17 (bytes 0x2E write, 0x2F read)
// (R5) four-wire link runs in clock mode 0 or 3 only
// (R6) four-wire write bursts to incrementing addresses while select stays low
// (R7) four-wire read bursts from incrementing addresses while select stays low
// (R8) address byte sets the pointer; select release or stop ends the burst
module shrp_port
   import shrp_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // straps
   input wire logic address_strap_pin_i,
   input wire logic spi_select_i,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // four-wire link
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic select_low_active_i,
   output logic so_o,
   output logic so_oe_o,
   // register file side
   output shrp_req_t req_o,
   input wire logic [7:0] rdata_i
);
   logic [SHRP_SYNC_W-1:0] raw;
   logic [SHRP_SYNC_W-1:0] sy1_reg;
   logic [SHRP_SYNC_W-1:0] sy2_reg;
   logic [SHRP_SYNC_W-1:0] prev_reg;
   logic scl_s, sda_s, sck_s, si_s, csn_s, strap_s, spi_s;
   logic scl_rise, scl_fall, sck_rise, i2c_start, i2c_stop;
   logic [6:0] dev_addr;
   logic [7:0] spi_byte;
   assign raw = {spi_select_i, address_strap_pin_i, select_low_active_i, si_i, sck_i,
                 sda_i, scl_i};
   // two flops per pin plus a delayed copy; the logic reads the second flop and the copy
   genvar g;
   generate
      for (g = 0; g < SHRP_SYNC_W; g++) begin : g_sync
         always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
               sy1_reg[g] <= SHRP_SYNC_RST[g];
               sy2_reg[g] <= SHRP_SYNC_RST[g];
               prev_reg[g] <= SHRP_SYNC_RST[g];
            end else if (ce_i) begin
               sy1_reg[g] <= raw[g];
               sy2_reg[g] <= sy1_reg[g];
               prev_reg[g] <= sy2_reg[g];
            end
         end
      end
   endgenerate
   assign scl_s = sy2_reg[SHRP_SY_SCL];
   assign sda_s = sy2_reg[SHRP_SY_SDA];
   assign sck_s = sy2_reg[SHRP_SY_SCK];
   assign si_s = sy2_reg[SHRP_SY_SI];
   assign csn_s = sy2_reg[SHRP_SY_CSN];
   assign strap_s = sy2_reg[SHRP_SY_STRAP];
   assign spi_s = sy2_reg[SHRP_SY_SPI];
   assign scl_rise = scl_s & ~prev_reg[SHRP_SY_SCL];
   assign scl_fall = ~scl_s & prev_reg[SHRP_SY_SCL];
   assign sck_rise = sck_s & ~prev_reg[SHRP_SY_SCK];
   assign i2c_start = scl_s & prev_reg[SHRP_SY_SCL] & prev_reg[SHRP_SY_SDA] & ~sda_s;
   assign i2c_stop = scl_s & prev_reg[SHRP_SY_SCL] & ~prev_reg[SHRP_SY_SDA] & sda_s;
   assign dev_addr = strap_s ? SHRP_DEV_ADDR_HIGH : SHRP_DEV_ADDR_LOW; // R3 R4
   shrp_state_t st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] ptr_reg, ptr_next;
   logic sdaoe_reg, sdaoe_next;
   logic sooe_reg, sooe_next;
   logic flag_reg, flag_next;
   logic load_reg, load_next;
   shrp_req_t req_reg, req_next;
   assign spi_byte = {sh_reg[6:0], si_s};
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      tx_next = load_reg ? rdata_i : tx_reg;
      ptr_next = ptr_reg;
      sdaoe_next = sdaoe_reg;
      sooe_next = sooe_reg;
      flag_next = flag_reg;
      load_next = 1'b0;
      req_next = req_reg;
      req_next.wr = 1'b0;
      req_next.rd = 1'b0;
      if (!spi_s) begin
         sooe_next = 1'b0;
         if (i2c_start) begin
            st_next = SHRP_I_DEV;
            // the start's own scl fall lands in the acknowledge branch, not as a bit
            cnt_next = SHRP_BIT_ACK;
            sdaoe_next = 1'b0;
         end else if (i2c_stop) begin
            st_next = SHRP_IDLE; // R8
            sdaoe_next = 1'b0;
         end else if (st_reg != SHRP_IDLE && scl_rise) begin
            // host acknowledge sampled in slot 8; low means go on
            if (cnt_reg == SHRP_BIT_ACK) begin
               flag_next = sda_s;
            end else begin
               sh_next = {sh_reg[6:0], sda_s};
            end
         end else if (st_reg != SHRP_IDLE && scl_fall) begin
            if (cnt_reg == SHRP_BIT_ACK) begin
               cnt_next = SHRP_BIT_RST;
               sdaoe_next = 1'b0;
               if (st_reg == SHRP_I_RD) begin
                  if (flag_reg) begin
                     st_next = SHRP_IDLE;
                  end else begin
                     tx_next = rdata_i;
                     sdaoe_next = ~rdata_i[7];
                  end
               end
            end else if (cnt_reg == SHRP_BIT_LAST) begin
               cnt_next = SHRP_BIT_ACK;
               case (st_reg)
                  SHRP_I_DEV: begin
                     if (sh_reg[7:1] == dev_addr) begin // R3 R4
                        sdaoe_next = 1'b1;
                        if (sh_reg[0]) begin
                           st_next = SHRP_I_RD;
                           req_next.rd = 1'b1;
                           req_next.addr = ptr_reg;
                        end else begin
                           st_next = SHRP_I_PTR;
                        end
                     end else begin
                        st_next = SHRP_IDLE;
                     end
                  end
                  SHRP_I_PTR: begin
                     ptr_next = sh_reg; // R8
                     sdaoe_next = 1'b1;
                     st_next = SHRP_I_WR;
                  end
                  SHRP_I_WR: begin
                     req_next.wr = 1'b1; // R1
                     req_next.addr = ptr_reg;
                     req_next.wdata = sh_reg;
                     ptr_next = ptr_reg + 8'h01;
                     sdaoe_next = 1'b1;
                  end
                  SHRP_I_RD: begin
                     // fetch ahead so the byte is ready at the acknowledge
                     sdaoe_next = 1'b0;
                     ptr_next = ptr_reg + 8'h01; // R2
                     req_next.rd = 1'b1;
                     req_next.addr = ptr_reg + 8'h01;
                  end
                  default: st_next = SHRP_IDLE;
               endcase
            end else begin
               cnt_next = cnt_reg + 4'h1;
               if (st_reg == SHRP_I_RD) begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  sdaoe_next = ~tx_reg[6];
               end
            end
         end
      end else begin
         sdaoe_next = 1'b0;
         if (csn_s) begin
            st_next = SHRP_IDLE; // R6 R7 R8
            sooe_next = 1'b0;
            cnt_next = SHRP_BIT_RST;
         end else if (st_reg == SHRP_IDLE) begin
            st_next = SHRP_S_CMD;
            cnt_next = SHRP_BIT_RST;
         end else if (sck_rise) begin
            // modes 0 and 3 both sample on the rising edge; output moves
            // just after it, well ahead of the next sampling edge
            sh_next = spi_byte; // R5
            tx_next = {tx_reg[6:0], 1'b0};
            if (cnt_reg == SHRP_BIT_LAST) begin
               cnt_next = SHRP_BIT_RST;
               case (st_reg)
                  SHRP_S_CMD: begin
                     if (spi_byte == SHRP_SPI_CMD_READ) begin
                        flag_next = 1'b1;
                        st_next = SHRP_S_ADDR;
                     end else if (spi_byte == SHRP_SPI_CMD_WRITE) begin
                        flag_next = 1'b0;
                        st_next = SHRP_S_ADDR;
                     end else begin
                        st_next = SHRP_S_SKIP;
                     end
                  end
                  SHRP_S_ADDR: begin
                     ptr_next = spi_byte; // R8
                     if (flag_reg) begin
                        st_next = SHRP_S_RD;
                        req_next.rd = 1'b1;
                        req_next.addr = spi_byte;
                        load_next = 1'b1;
                        sooe_next = 1'b1;
                     end else begin
                        st_next = SHRP_S_WR;
                     end
                  end
                  SHRP_S_WR: begin
                     req_next.wr = 1'b1; // R6
                     req_next.addr = ptr_reg;
                     req_next.wdata = spi_byte;
                     ptr_next = ptr_reg + 8'h01;
                  end
                  SHRP_S_RD: begin
                     ptr_next = ptr_reg + 8'h01; // R7
                     req_next.rd = 1'b1;
                     req_next.addr = ptr_reg + 8'h01;
                     load_next = 1'b1;
                  end
                  default: st_next = st_reg;
               endcase
            end else begin
               cnt_next = cnt_reg + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         st_reg <= SHRP_IDLE;
         cnt_reg <= SHRP_BIT_RST;
         sh_reg <= SHRP_PTR_RST;
         tx_reg <= SHRP_PTR_RST;
         ptr_reg <= SHRP_PTR_RST;
         sdaoe_reg <= 1'b0;
         sooe_reg <= 1'b0;
         flag_reg <= 1'b0;
         load_reg <= 1'b0;
         req_reg <= SHRP_REQ_RST;
      end else if (ce_i) begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         sdaoe_reg <= sdaoe_next;
         sooe_reg <= sooe_next;
         flag_reg <= flag_next;
         load_reg <= load_next;
         req_reg <= req_next;
      end
   end
   // open drain: the level is always low, only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe_o = sdaoe_reg;
   assign so_o = tx_reg[7];
   assign so_oe_o = sooe_reg;
   assign req_o = req_reg;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sequence dev_byte_done_s;
      ce_i && !spi_s && st_reg == SHRP_I_DEV && scl_fall && cnt_reg == SHRP_BIT_LAST;
   endsequence
   sequence spi_wr_s;
      ce_i && spi_s && req_reg.wr;
   endsequence
   i2c_wr_incr_a: assert property (ce_i && !spi_s && req_reg.wr |-> ptr_reg == req_reg.addr + 8'h01) // R1
      else $error("two-wire write did not advance the pointer");
   i2c_rd_incr_a: assert property (req_reg.rd && $past(st_reg) == SHRP_I_RD
      |-> req_reg.addr == $past(ptr_reg) + 8'h01) // R2
      else $error("two-wire read did not advance the address");
   addr_low_a: assert property (dev_byte_done_s ##0 (!strap_s)
      |=> sdaoe_reg == ($past(sh_reg[7:1]) == 7'h16)) // R3
      else $error("strap low address answer wrong");
   addr_high_a: assert property (dev_byte_done_s ##0 strap_s
      |=> sdaoe_reg == ($past(sh_reg[7:1]) == 7'h17)) // R4
      else $error("strap high address answer wrong");
   so_drive_a: assert property (so_oe_o |-> spi_s && (!csn_s || st_reg != SHRP_IDLE)) // R5
      else $error("serial output driven outside a selected frame");
   spi_wr_incr_a: assert property (spi_wr_s |-> ptr_reg == req_reg.addr + 8'h01) // R6
      else $error("four-wire write did not advance the pointer");
   spi_rd_load_a: assert property (ce_i && spi_s && req_reg.rd ##1 ce_i
      |-> tx_reg == $past(rdata_i)) // R7
      else $error("four-wire read byte not loaded");
   cs_end_a: assert property (ce_i && spi_s && csn_s |=> st_reg == SHRP_IDLE && !so_oe_o) // R8
      else $error("burst not ended by select release");
endmodule
`default_nettype wire

// ==== sim/shrp_host_model.sv ====
// host master model driving the two-wire bus and the four-wire link
`default_nettype none
module shrp_host_model (
   // clock
   input wire logic clk_sys_i,
   // two-wire bus, sda_o high means released
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i,
   // four-wire link
   output logic sck_o,
   output logic si_o,
   output logic cs_n_o,
   input wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mode3 = 1'b0;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      cs_n_o = 1'b1;
   end
   // pins move only just after a system edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // start when st is high, stop otherwise; sda is set up first, then the start or stop edge comes while scl is high
   task automatic cond(input logic st);
      sda_o = st;
      wt(5);
      scl_o = 1'b1;
      wt(5);
      sda_o = !st;
      wt(5);
      scl_o = !st;
      wt(5);
   endtask
   // 160 ns bit: data set while low, wire read late in the high phase
   task automatic bit_slot(input logic d, output logic r);
      sda_o = d;
      wt(5);
      scl_o = 1'b1;
      wt(8);
      r = sda_i;
      wt(2);
      scl_o = 1'b0;
      wt(5);
   endtask
   // eight bits msb first, then the acknowledge slot in rx[0]
   task automatic byte_slot(input logic [7:0] tx, input logic last, output logic [8:0] rx);
      for (int i = 7; i >= 0; i--) bit_slot(tx[i], rx[i+1]);
      bit_slot(last, rx[0]);
   endtask
   // clock idles low in mode 0, high in mode 3
   task automatic spi_begin(input logic m);
      mode3 = m;
      sck_o = m;
      wt(5);
      cs_n_o = 1'b0;
      wt(10);
   endtask
   // data changes while sck low, sampled by both sides on the rise
   task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_o = 1'b0;
         si_o = tx[i];
         wt(10);
         rx[i] = so_i;
         sck_o = 1'b1;
         wt(10);
      end
   endtask
   // si no longer held after the frame, so it flips; 400 ns deselect gap
   task automatic spi_end();
      sck_o = mode3;
      wt(10);
      cs_n_o = 1'b1;
      si_o = ~si_o;
      wt(50);
   endtask
endmodule
`default_nettype wire

// ==== sim/shrp_port_tb_top.sv ====
// self-checking bench for the serial host register port
`default_nettype none
module shrp_port_tb_top
   import shrp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic strap = 1'b0;
   logic spi_sel = 1'b0;
   logic ce = 1'b1;
   logic scl, sda_h, sck, si, cs_n, sda_o, sda_oe, so, so_oe;
   logic [7:0] mem [256];
   shrp_req_t req;
   // combinational read of the held address: the port takes its
   // four-wire byte in the very cycle of the read pulse
   wire logic [7:0] rdata = mem[req.addr];
   int n_fail = 0;
   int checked = 0;
   // pulled-up open-drain wire; released select leaves so inverted
   wire logic sda_w = sda_h & ~(sda_oe & ~sda_o);
   wire logic so_w = so_oe ? so : ~so;

   shrp_port dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce),
      .address_strap_pin_i(strap), .spi_select_i(spi_sel), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .sck_i(sck), .si_i(si),
      .select_low_active_i(cs_n), .so_o(so), .so_oe_o(so_oe), .req_o(req), .rdata_i(rdata));
   shrp_host_model host (.clk_sys_i(clk_sys_i), .scl_o(scl), .sda_o(sda_h), .sda_i(sda_w),
      .sck_o(sck), .si_o(si), .cs_n_o(cs_n), .so_i(so_w));

   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // register file: written at the edge that sees the pulse
   always @(posedge clk_sys_i) begin
      if (req.wr === 1'b1) mem[req.addr] <= req.wdata;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // foreign address ignored, then burst write and burst read
   task automatic t_i2c(input logic s, input logic [7:0] b);
      logic [7:0] dw;
      logic [8:0] rx;
      dw = s ? 8'h2e : 8'h2c;
      host.cond(1'b1);
      host.byte_slot(s ? 8'h2c : 8'h2e, 1'b1, rx);
      check({7'h00, rx[0]}, 8'h01);
      host.cond(1'b0);
      host.cond(1'b1);
      host.byte_slot(dw, 1'b1, rx);
      check({7'h00, rx[0]}, 8'h00);
      host.byte_slot(b, 1'b1, rx);
      for (int k = 0; k < 3; k++) begin
         host.byte_slot(8'(b + k) ^ 8'hc3, 1'b1, rx);
         check({7'h00, rx[0]}, 8'h00);
      end
      host.cond(1'b0);
      for (int k = 0; k < 3; k++) check(mem[8'(b + k)], 8'(b + k) ^ 8'hc3);
      host.cond(1'b1);
      host.byte_slot(dw, 1'b1, rx);
      host.byte_slot(b, 1'b1, rx);
      host.cond(1'b1);
      host.byte_slot(dw | 8'h01, 1'b1, rx);
      check({7'h00, rx[0]}, 8'h00);
      for (int k = 0; k < 3; k++) begin
         host.byte_slot(8'hff, k == 2, rx);
         check(rx[8:1], 8'(b + k) ^ 8'hc3);
      end
      host.cond(1'b0);
   endtask

   // burst write, refused command frame, burst read
   task automatic t_spi(input logic m, input logic [7:0] b);
      logic [7:0] v;
      host.spi_begin(m);
      host.spi_xfer(SHRP_SPI_CMD_WRITE, v);
      host.spi_xfer(b, v);
      for (int k = 0; k < 3; k++) host.spi_xfer(8'(b + k) ^ 8'h3c, v);
      host.spi_end();
      host.spi_begin(m);
      host.spi_xfer(8'h5a, v);
      host.spi_xfer(b, v);
      host.spi_xfer(8'hee, v);
      host.spi_end();
      for (int k = 0; k < 3; k++) check(mem[8'(b + k)], 8'(b + k) ^ 8'h3c);
      host.spi_begin(m);
      host.spi_xfer(SHRP_SPI_CMD_READ, v);
      host.spi_xfer(b, v);
      for (int k = 0; k < 3; k++) begin
         host.spi_xfer(8'h00, v);
         check(v, 8'(b + k) ^ 8'h3c);
      end
      host.spi_end();
   endtask

   // enable low: a whole write frame passes unseen, pins resume cleanly after
   task automatic t_freeze();
      logic [7:0] v;
      ce = 1'b0;
      host.spi_begin(1'b0);
      host.spi_xfer(SHRP_SPI_CMD_WRITE, v);
      host.spi_xfer(8'h30, v);
      host.spi_xfer(8'h99, v);
      host.spi_end();
      ce = 1'b1;
      host.wt(10);
      check(mem[8'h30], 8'h30 ^ 8'h3c);
   endtask

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
      repeat (16) @(posedge clk_sys_i);
      #1;
      reset_i = 1'b0;
      host.wt(10);
      t_i2c(1'b0, 8'h10);
      strap = 1'b1;
      host.wt(10);
      t_i2c(1'b1, 8'h7d);
      spi_sel = 1'b1;
      host.wt(10);
      t_spi(1'b0, 8'h30);
      t_freeze();
      t_spi(1'b1, 8'hc0);
      finish_test();
   end

   // whole run needs about 80 us
   initial begin
      #400us;
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
